/* File: rtl/aor_defs.vh */
// Register map, field layout and codes of the audio output router
`ifndef AOR_DEFS_VH
`define AOR_DEFS_VH

// Register indices; the byte address is four times the index
`define AOR_ROUTE_IDX   16'hF180
`define AOR_ROUTE_CNT   16'h0018
`define AOR_SPDIF_IDX   16'hF1C0
`define AOR_STATUS_IDX  16'hF1C4
`define AOR_SPCTL_IDX   16'hF200
`define AOR_SPCTL_LAST  16'hF21C
`define AOR_SPCTL_MEM   5'h18
`define AOR_LAST_PAIR   5'h17

// Reset values
`define AOR_REG_RST     16'h0000

// Routing register fields
`define AOR_SRC_LSB     0
`define AOR_SRC_MSB     2
`define AOR_CONV_LSB    3
`define AOR_CONV_MSB    5
`define AOR_TXSRC_LSB   0
`define AOR_TXSRC_MSB   1

// Output pair source codes
`define AOR_SRC_OFF     3'h0
`define AOR_SRC_SIN     3'h1
`define AOR_SRC_DSP     3'h2
`define AOR_SRC_CONV    3'h3
`define AOR_SRC_PDM01   3'h4
`define AOR_SRC_PDM23   3'h5

// Transmitter source codes
`define AOR_TX_OFF      2'h0
`define AOR_TX_DSP      2'h1
`define AOR_TX_RX       2'h2

// Bus decode regions
`define AOR_RGN_NONE    2'h0
`define AOR_RGN_MEM     2'h1
`define AOR_RGN_SPDIF   2'h2
`define AOR_RGN_STATUS  2'h3

`endif

/* File: rtl/aor_cfg_mem.v */
// Configuration word store with one write port and two registered read ports
`timescale 1ns/1ps
`include "aor_defs.vh"
module aor_cfg_mem #(
   parameter DATA_W = 16,
   parameter ADDR_W = 5,
   parameter DEPTH  = 32
) (
   // Clock and reset
   input  wire              clk_i,
   input  wire              sys_rst_i,
   // Write port
   input  wire              wr_en_i,
   input  wire [ADDR_W-1:0] wr_addr_i,
   input  wire [DATA_W-1:0] wr_data_i,
   // Read ports
   input  wire [ADDR_W-1:0] a_addr_i,
   output reg  [DATA_W-1:0] a_data_o,
   input  wire [ADDR_W-1:0] b_addr_i,
   output reg  [DATA_W-1:0] b_data_o
);

   reg [DATA_W-1:0] mem_reg [0:DEPTH-1];
   integer i;

   // Every word clears so all selectors start disabled
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         for (i = 0; i < DEPTH; i = i + 1) begin
            mem_reg[i] <= `AOR_REG_RST;
         end
         a_data_o <= `AOR_REG_RST;
         b_data_o <= `AOR_REG_RST;
      end else begin
         if (wr_en_i) begin
            mem_reg[wr_addr_i] <= wr_data_i;
         end
         a_data_o <= mem_reg[a_addr_i];
         b_data_o <= mem_reg[b_addr_i];
      end
   end

endmodule

/* File: rtl/aor_pair_buf.v */
// Two-entry skid buffer with registered outputs
`timescale 1ns/1ps
module aor_pair_buf #(
   parameter WIDTH = 69
) (
   // Clock and reset
   input  wire             clk_i,
   input  wire             sys_rst_i,
   // Filling side
   input  wire             in_valid_i,
   output reg              in_ready_o,
   input  wire [WIDTH-1:0] in_data_i,
   // Draining side
   output reg              out_valid_o,
   input  wire             out_ready_i,
   output reg  [WIDTH-1:0] out_data_o
);

   reg [WIDTH-1:0] skid_data_reg;
   reg             skid_valid_reg;
   reg             skid_valid_next;
   wire            push;
   wire            pop;

   assign push = in_valid_i & in_ready_o;
   assign pop  = out_valid_o & out_ready_i;

   always @* begin
      skid_valid_next = skid_valid_reg;
      if (pop || !out_valid_o) begin
         skid_valid_next = 1'b0;
      end else if (push) begin
         skid_valid_next = 1'b1;
      end
   end

   // Ready is registered, so the skid slot catches the word already in flight
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         out_valid_o    <= 1'b0;
         out_data_o     <= {WIDTH{1'b0}};
         skid_data_reg  <= {WIDTH{1'b0}};
         skid_valid_reg <= 1'b0;
         in_ready_o     <= 1'b0;
      end else begin
         skid_valid_reg <= skid_valid_next;
         in_ready_o     <= ~skid_valid_next;
         if (pop || !out_valid_o) begin
            if (skid_valid_reg) begin
               out_data_o  <= skid_data_reg;
               out_valid_o <= 1'b1;
            end else begin
               out_valid_o <= push;
               if (push) begin
                  out_data_o <= in_data_i;
               end
            end
         end else if (push) begin
            skid_data_reg <= in_data_i;
         end
      end
   end

endmodule

/* File: rtl/aor_router.v */
// Audio output source router with Avalon-MM register slave
//
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "aor_defs.vh"
module aor_router #(
   parameter SAMPLE_W = 32
) (
   // Clock and reset
   input  wire                    clk_i,
   input  wire                    sys_rst_i,
   // Avalon-MM slave
   input  wire [17:0]             avs_address_i,
   input  wire                    avs_read_i,
   input  wire                    avs_write_i,
   input  wire [3:0]              avs_byteenable_i,
   input  wire [31:0]             avs_writedata_i,
   output reg  [31:0]             avs_readdata_o,
   output reg                     avs_waitrequest_o,
   // Audio sources, channel n at bits n*SAMPLE_W upward
   input  wire                    frame_start_i,
   input  wire [48*SAMPLE_W-1:0]  serial_in_line_i,
   input  wire [48*SAMPLE_W-1:0]  dsp_out_i,
   input  wire [16*SAMPLE_W-1:0]  conv_out_i,
   input  wire [4*SAMPLE_W-1:0]   pdm_in_i,
   // Routed output pairs toward the serial output ports
   output wire                    pair_valid_o,
   input  wire                    pair_ready_i,
   output wire [4:0]              pair_index_o,
   output wire [SAMPLE_W-1:0]     pair_left_o,
   output wire [SAMPLE_W-1:0]     pair_right_o,
   // S/PDIF transmitter feed
   input  wire [SAMPLE_W-1:0]     dsp_spdif_left_i,
   input  wire [SAMPLE_W-1:0]     dsp_spdif_right_i,
   input  wire                    dsp_spdif_valid_i,
   input  wire [SAMPLE_W-1:0]     spdif_rx_left_i,
   input  wire [SAMPLE_W-1:0]     spdif_rx_right_i,
   input  wire                    spdif_rx_valid_i,
   output reg                     spdif_tx_enable_o,
   output reg                     spdif_tx_valid_o,
   output reg  [SAMPLE_W-1:0]     spdif_tx_left_o,
   output reg  [SAMPLE_W-1:0]     spdif_tx_right_o
);

   localparam BUF_W = 5 + 2 * SAMPLE_W;

   localparam BUS_IDLE = 2'h0;
   localparam BUS_LOOK = 2'h1;
   localparam BUS_ACK  = 2'h2;

   localparam SCAN_IDLE = 2'h0;
   localparam SCAN_READ = 2'h1;
   localparam SCAN_EVAL = 2'h2;

   // Returns {region, memory address} for a register index
   function [6:0] aor_decode;
      input [15:0] idx;
      reg   [15:0] off;
      begin
         aor_decode = {`AOR_RGN_NONE, 5'h00};
         off = idx - `AOR_ROUTE_IDX;
         if (off < `AOR_ROUTE_CNT) begin
            aor_decode = {`AOR_RGN_MEM, off[4:0]};
         end else if (idx == `AOR_SPDIF_IDX) begin
            aor_decode = {`AOR_RGN_SPDIF, 5'h00};
         end else if (idx == `AOR_STATUS_IDX) begin
            aor_decode = {`AOR_RGN_STATUS, 5'h00};
         end else if (idx >= `AOR_SPCTL_IDX && idx <= `AOR_SPCTL_LAST
                      && idx[1:0] == 2'h0) begin
            off = idx - `AOR_SPCTL_IDX;
            // Inputs 0..3 then outputs 0..3, one word every four indices
            aor_decode = {`AOR_RGN_MEM, `AOR_SPCTL_MEM + {2'h0, off[4:2]}};
         end
      end
   endfunction

   // Byte-lane merge of a write into the stored 16-bit value
   function [15:0] aor_merge;
      input [15:0] old_val;
      input [31:0] wdata;
      input [3:0]  be;
      begin
         aor_merge[7:0]  = be[0] ? wdata[7:0]  : old_val[7:0];
         aor_merge[15:8] = be[1] ? wdata[15:8] : old_val[15:8];
      end
   endfunction

   // Bus slave
   reg  [1:0]          bus_state_reg;
   reg  [15:0]         spdif_src_reg;
   wire [6:0]          dec;
   wire [1:0]          region;
   wire [4:0]          mem_addr;
   wire [15:0]         mem_a_data;
   wire [15:0]         mem_b_data;
   wire                mem_wr;
   wire [15:0]         merged;
   wire [15:0]         status_word;
   wire                bus_req;

   assign dec      = aor_decode(avs_address_i[17:2]);
   assign region   = dec[6:5];
   assign mem_addr = dec[4:0];
   assign bus_req  = avs_read_i | avs_write_i;
   assign merged   = aor_merge(avs_readdata_o[15:0], avs_writedata_i, avs_byteenable_i);
   assign mem_wr   = (bus_state_reg == BUS_ACK) && avs_write_i && (region == `AOR_RGN_MEM);

   // Request seen at edge 1, data and waitrequest low at edge 2, done at edge 3
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         bus_state_reg     <= BUS_IDLE;
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o    <= 32'h0000_0000;
         spdif_src_reg     <= `AOR_REG_RST;
      end else begin
         case (bus_state_reg)
            BUS_IDLE: begin
               if (bus_req) begin
                  bus_state_reg <= BUS_LOOK;
               end
            end
            BUS_LOOK: begin
               avs_waitrequest_o <= 1'b0;
               bus_state_reg     <= BUS_ACK;
               case (region)
                  `AOR_RGN_MEM:    avs_readdata_o <= {16'h0000, mem_a_data};
                  `AOR_RGN_SPDIF:  avs_readdata_o <= {16'h0000, spdif_src_reg};
                  `AOR_RGN_STATUS: avs_readdata_o <= {16'h0000, status_word};
                  default:         avs_readdata_o <= 32'h0000_0000;
               endcase
            end
            BUS_ACK: begin
               avs_waitrequest_o <= 1'b1;
               bus_state_reg     <= BUS_IDLE;
               if (avs_write_i && region == `AOR_RGN_SPDIF) begin
                  spdif_src_reg <= merged;
               end
            end
            default: begin
               bus_state_reg     <= BUS_IDLE;
               avs_waitrequest_o <= 1'b1;
            end
         endcase
      end
   end

   // Routing scan, one pair per two cycles unless stalled, from a frame start seen while idle
   reg  [1:0]          scan_state_reg;
   reg  [4:0]          pair_reg;
   reg                 has_data;
   reg  [SAMPLE_W-1:0] sel_left;
   reg  [SAMPLE_W-1:0] sel_right;
   wire [2:0]          src_sel;
   wire [2:0]          conv_sel;
   wire                buf_ready;
   wire                buf_push;
   wire [BUF_W-1:0]    buf_out;

   aor_cfg_mem #(
      .DATA_W (16),
      .ADDR_W (5),
      .DEPTH  (32)
   ) u_cfg_mem (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .wr_en_i   (mem_wr),
      .wr_addr_i (mem_addr),
      .wr_data_i (merged),
      .a_addr_i  (mem_addr),
      .a_data_o  (mem_a_data),
      .b_addr_i  (pair_reg),
      .b_data_o  (mem_b_data)
   );

   assign src_sel  = mem_b_data[`AOR_SRC_MSB:`AOR_SRC_LSB];
   assign conv_sel = mem_b_data[`AOR_CONV_MSB:`AOR_CONV_LSB];

   always @* begin
      has_data  = 1'b1;
      sel_left  = {SAMPLE_W{1'b0}};
      sel_right = {SAMPLE_W{1'b0}};
      case (src_sel)
         `AOR_SRC_SIN: begin
            sel_left  = serial_in_line_i[(2 * pair_reg) * SAMPLE_W +: SAMPLE_W];
            sel_right = serial_in_line_i[(2 * pair_reg + 1) * SAMPLE_W +: SAMPLE_W];
         end
         `AOR_SRC_DSP: begin
            sel_left  = dsp_out_i[(2 * pair_reg) * SAMPLE_W +: SAMPLE_W];
            sel_right = dsp_out_i[(2 * pair_reg + 1) * SAMPLE_W +: SAMPLE_W];
         end
         `AOR_SRC_CONV: begin
            // Converter field only matters under this code
            sel_left  = conv_out_i[(2 * conv_sel) * SAMPLE_W +: SAMPLE_W];
            sel_right = conv_out_i[(2 * conv_sel + 1) * SAMPLE_W +: SAMPLE_W];
         end
         `AOR_SRC_PDM01: begin
            sel_left  = pdm_in_i[0 +: SAMPLE_W];
            sel_right = pdm_in_i[SAMPLE_W +: SAMPLE_W];
         end
         `AOR_SRC_PDM23: begin
            sel_left  = pdm_in_i[2 * SAMPLE_W +: SAMPLE_W];
            sel_right = pdm_in_i[3 * SAMPLE_W +: SAMPLE_W];
         end
         default: begin
            has_data = 1'b0;
         end
      endcase
   end

   assign buf_push = (scan_state_reg == SCAN_EVAL) && has_data;

   // A frame start during a scan is dropped; sources must hold still per frame
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         scan_state_reg <= SCAN_IDLE;
         pair_reg       <= 5'h00;
      end else begin
         case (scan_state_reg)
            SCAN_IDLE: begin
               if (frame_start_i) begin
                  pair_reg       <= 5'h00;
                  scan_state_reg <= SCAN_READ;
               end
            end
            SCAN_READ: begin
               scan_state_reg <= SCAN_EVAL;
            end
            SCAN_EVAL: begin
               // Stall on a full buffer so no routed pair is lost
               if (!has_data || buf_ready) begin
                  if (pair_reg == `AOR_LAST_PAIR) begin
                     scan_state_reg <= SCAN_IDLE;
                  end else begin
                     pair_reg       <= pair_reg + 5'h01;
                     scan_state_reg <= SCAN_READ;
                  end
               end
            end
            default: begin
               scan_state_reg <= SCAN_IDLE;
            end
         endcase
      end
   end

   aor_pair_buf #(
      .WIDTH (BUF_W)
   ) u_pair_buf (
      .clk_i       (clk_i),
      .sys_rst_i   (sys_rst_i),
      .in_valid_i  (buf_push),
      .in_ready_o  (buf_ready),
      .in_data_i   ({pair_reg, sel_left, sel_right}),
      .out_valid_o (pair_valid_o),
      .out_ready_i (pair_ready_i),
      .out_data_o  (buf_out)
   );

   assign pair_index_o = buf_out[BUF_W-1 -: 5];
   assign pair_left_o  = buf_out[2*SAMPLE_W-1 -: SAMPLE_W];
   assign pair_right_o = buf_out[SAMPLE_W-1:0];

   assign status_word = {12'h000, (buf_push & ~buf_ready), pair_valid_o,
                         ~buf_ready, (scan_state_reg != SCAN_IDLE)};

   // S/PDIF transmitter feed
   wire [1:0] tx_sel;
   assign tx_sel = spdif_src_reg[`AOR_TXSRC_MSB:`AOR_TXSRC_LSB];

   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         spdif_tx_enable_o <= 1'b0;
         spdif_tx_valid_o  <= 1'b0;
         spdif_tx_left_o   <= {SAMPLE_W{1'b0}};
         spdif_tx_right_o  <= {SAMPLE_W{1'b0}};
      end else begin
         case (tx_sel)
            `AOR_TX_DSP: begin
               spdif_tx_enable_o <= 1'b1;
               spdif_tx_valid_o  <= dsp_spdif_valid_i;
               spdif_tx_left_o   <= dsp_spdif_left_i;
               spdif_tx_right_o  <= dsp_spdif_right_i;
            end
            `AOR_TX_RX: begin
               spdif_tx_enable_o <= 1'b1;
               spdif_tx_valid_o  <= spdif_rx_valid_i;
               spdif_tx_left_o   <= spdif_rx_left_i;
               spdif_tx_right_o  <= spdif_rx_right_i;
            end
            default: begin
               spdif_tx_enable_o <= 1'b0;
               spdif_tx_valid_o  <= 1'b0;
               spdif_tx_left_o   <= {SAMPLE_W{1'b0}};
               spdif_tx_right_o  <= {SAMPLE_W{1'b0}};
            end
         endcase
      end
   end

endmodule

/* File: testbench/aor_router_props.sv */
// Concurrent checks on the router's bus, pair stream and transmitter feed
`timescale 1ns/1ps
module aor_router_props #(
   parameter SAMPLE_W = 32
) (
   // Clock and reset
   input logic                clk_i,
   input logic                sys_rst_i,
   // Register bus
   input logic [17:0]         avs_address_i,
   input logic                avs_read_i,
   input logic                avs_write_i,
   input logic [31:0]         avs_readdata_o,
   input logic                avs_waitrequest_o,
   // Pair stream
   input logic                pair_valid_o,
   input logic                pair_ready_i,
   input logic [4:0]          pair_index_o,
   input logic [SAMPLE_W-1:0] pair_left_o,
   // Transmitter feed
   input logic [SAMPLE_W-1:0] dsp_spdif_left_i,
   input logic                dsp_spdif_valid_i,
   input logic [SAMPLE_W-1:0] spdif_rx_left_i,
   input logic                spdif_rx_valid_i,
   input logic                spdif_tx_enable_o,
   input logic                spdif_tx_valid_o,
   input logic [SAMPLE_W-1:0] spdif_tx_left_o
);
   wire req = avs_read_i | avs_write_i;
   wire [15:0] idx = avs_address_i[17:2];
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   AST_WAIT_TWO: assert property ($rose(req) |-> avs_waitrequest_o ##1 avs_waitrequest_o
      ##1 !avs_waitrequest_o) else $error("bus answer not two cycles after request");
   AST_WAIT_ONE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low longer than one cycle");
   AST_RDATA_HI: assert property (avs_readdata_o[31:16] == 16'h0000)
      else $error("upper read data not zero");
   AST_UNMAPPED: assert property (!avs_waitrequest_o && avs_read_i && idx >= 16'hF198
      && idx <= 16'hF1BF |-> avs_readdata_o == 32'h0000_0000) else $error("gap read not zero");
   AST_TX_OFF: assert property (!spdif_tx_enable_o && !$past(spdif_tx_enable_o)
      |-> spdif_tx_left_o == '0 && !spdif_tx_valid_o) else $error("disabled feed not quiet");
   AST_TX_SRC: assert property (spdif_tx_enable_o && $past(spdif_tx_enable_o) |->
      (spdif_tx_left_o == $past(dsp_spdif_left_i) && spdif_tx_valid_o == $past(dsp_spdif_valid_i))
      || (spdif_tx_left_o == $past(spdif_rx_left_i) && spdif_tx_valid_o == $past(spdif_rx_valid_i)))
      else $error("transmitter data from no selected source");
   AST_PAIR_HOLD: assert property (pair_valid_o && !pair_ready_i |=> pair_valid_o
      && $stable(pair_index_o) && $stable(pair_left_o)) else $error("stalled pair changed");
   AST_IDX_RANGE: assert property (pair_valid_o |-> pair_index_o <= 5'h17)
      else $error("pair index beyond last pair");
   AST_QUIET_RESET: assert property ($fell(sys_rst_i) |-> !pair_valid_o
      && !spdif_tx_enable_o) else $error("outputs active after reset");
   cover property (pair_valid_o && pair_ready_i);
   cover property (pair_valid_o && !pair_ready_i ##1 pair_valid_o && !pair_ready_i);
   cover property (spdif_tx_enable_o && spdif_tx_valid_o);
   cover property (!avs_waitrequest_o && avs_write_i);
endmodule

bind aor_router aor_router_props #(.SAMPLE_W(SAMPLE_W)) props_u (
   .clk_i(clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i),
   .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o), .pair_valid_o(pair_valid_o),
   .pair_ready_i(pair_ready_i), .pair_index_o(pair_index_o), .pair_left_o(pair_left_o),
   .dsp_spdif_left_i(dsp_spdif_left_i), .dsp_spdif_valid_i(dsp_spdif_valid_i),
   .spdif_rx_left_i(spdif_rx_left_i), .spdif_rx_valid_i(spdif_rx_valid_i),
   .spdif_tx_enable_o(spdif_tx_enable_o), .spdif_tx_valid_o(spdif_tx_valid_o),
   .spdif_tx_left_o(spdif_tx_left_o));

/* File: testbench/aor_pair_sink.sv */
// Receiver of routed pairs standing in for the serial output ports
`timescale 1ns/1ps
module aor_pair_sink (
   // Clock and reset
   input  logic        clk_i,
   input  logic        sys_rst_i,
   // Bench control
   input  logic        hold_i,
   // Pair stream
   input  logic        pair_valid_i,
   input  logic [4:0]  pair_index_i,
   input  logic [31:0] pair_left_i,
   input  logic [31:0] pair_right_i,
   output logic        pair_ready_o
);
   logic [1:0]  phase_reg;
   logic [68:0] rx_q[$];
   // Refuses every third cycle so the buffer meets stalls in mid-scan
   assign pair_ready_o = !hold_i && (phase_reg != 2'h2);
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         phase_reg <= 2'h0;
      end else begin
         phase_reg <= (phase_reg == 2'h2) ? 2'h0 : phase_reg + 2'h1;
         if (pair_valid_i && pair_ready_o) begin
            rx_q.push_back({pair_index_i, pair_left_i, pair_right_i});
         end
      end
   end
endmodule

/* File: testbench/aor_router_bench.sv */
// Self-checking bench for the audio output router
`timescale 1ns/1ps
module aor_router_bench;
   logic          clk_i = 1'b0;
   logic          sys_rst_i = 1'b1;
   logic [17:0]   avs_address_i = 18'h0_0000;
   logic          avs_read_i = 1'b0;
   logic          avs_write_i = 1'b0;
   logic [31:0]   avs_writedata_i = 32'h0000_0000;
   logic [3:0]    avs_byteenable_i = 4'hF;
   logic [3:0]    be_sel = 4'hF;
   wire  [31:0]   avs_readdata_o;
   wire           avs_waitrequest_o;
   logic          frame_start_i = 1'b0;
   logic [1535:0] serial_in_line_i;
   logic [1535:0] dsp_out_i;
   logic [511:0]  conv_out_i;
   logic [127:0]  pdm_in_i;
   wire           pair_valid_o;
   wire           pair_ready_i;
   wire  [4:0]    pair_index_o;
   wire  [31:0]   pair_left_o;
   wire  [31:0]   pair_right_o;
   logic          hold_i = 1'b0;
   logic          spdif_rx_valid_i = 1'b0;
   wire           spdif_tx_enable_o;
   wire           spdif_tx_valid_o;
   wire  [31:0]   spdif_tx_left_o;
   wire  [31:0]   spdif_tx_right_o;
   logic [31:0]   d;
   logic [68:0]   w;
   logic [68:0]   exp_q[$];
   int            errors = 0;
   int            cmp_count = 0;
   int            cyc = 0;
   int            n, k, p, c, code, conv;

   always #10 clk_i = ~clk_i;

   aor_router dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_byteenable_i(avs_byteenable_i),
      .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .frame_start_i(frame_start_i),
      .serial_in_line_i(serial_in_line_i), .dsp_out_i(dsp_out_i), .conv_out_i(conv_out_i),
      .pdm_in_i(pdm_in_i), .pair_valid_o(pair_valid_o), .pair_ready_i(pair_ready_i),
      .pair_index_o(pair_index_o), .pair_left_o(pair_left_o), .pair_right_o(pair_right_o),
      .dsp_spdif_left_i(32'hD000_0001), .dsp_spdif_right_i(32'hD000_0002),
      .dsp_spdif_valid_i(1'b1), .spdif_rx_left_i(32'hE000_0001),
      .spdif_rx_right_i(32'hE000_0002), .spdif_rx_valid_i(spdif_rx_valid_i),
      .spdif_tx_enable_o(spdif_tx_enable_o), .spdif_tx_valid_o(spdif_tx_valid_o),
      .spdif_tx_left_o(spdif_tx_left_o), .spdif_tx_right_o(spdif_tx_right_o));

   aor_pair_sink sink_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .hold_i(hold_i),
      .pair_valid_i(pair_valid_o), .pair_index_i(pair_index_o), .pair_left_i(pair_left_o),
      .pair_right_i(pair_right_o), .pair_ready_o(pair_ready_i));

   task tally_and_finish;
      begin
         $display("comparisons %0d mismatches %0d", cmp_count, errors);
         if (errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
         else $display("SIMULATION FAILED");
         $finish;
      end
   endtask

   task check(input logic [31:0] seen, input logic [31:0] expv);
      begin
         cmp_count++;
         if (seen !== expv) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, expv);
         end
      end
   endtask

   // One Avalon transfer; the request is held until waitrequest is seen low
   task acc(input logic wr, input logic [15:0] idx, input logic [15:0] wd,
            output logic [31:0] rd);
      begin
         @(posedge clk_i);
         avs_address_i <= {idx, 2'b00};
         avs_write_i <= wr;
         avs_read_i <= !wr;
         avs_writedata_i <= {16'h0000, wd};
         avs_byteenable_i <= be_sel;
         do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
         rd = avs_readdata_o;
         avs_write_i <= 1'b0;
         avs_read_i <= 1'b0;
      end
   endtask

   task rdchk(input logic [15:0] idx, input logic [31:0] expv);
      begin
         acc(1'b0, idx, 16'h0000, d);
         check(d, expv);
      end
   endtask

   function automatic logic [63:0] src_pair(input int kk, input int cd, input int cv);
      case (cd)
         1: src_pair = {32'h1000_0000 + 2 * kk, 32'h1000_0001 + 2 * kk};
         2: src_pair = {32'h2000_0000 + 2 * kk, 32'h2000_0001 + 2 * kk};
         3: src_pair = {32'h3000_0000 + 2 * cv, 32'h3000_0001 + 2 * cv};
         4: src_pair = {32'h4000_0000, 32'h4000_0001};
         5: src_pair = {32'h4000_0002, 32'h4000_0003};
         default: src_pair = 64'h0000_0000_0000_0000;
      endcase
   endfunction

   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         tally_and_finish;
      end
   end

   initial begin
      for (n = 0; n < 48; n++) begin
         serial_in_line_i[n*32 +: 32] = 32'h1000_0000 + n;
         dsp_out_i[n*32 +: 32] = 32'h2000_0000 + n;
      end
      for (n = 0; n < 16; n++) conv_out_i[n*32 +: 32] = 32'h3000_0000 + n;
      for (n = 0; n < 4; n++) pdm_in_i[n*32 +: 32] = 32'h4000_0000 + n;
      repeat (12) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      rdchk(16'hF180, 32'h0000_0000);
      rdchk(16'hF197, 32'h0000_0000);
      rdchk(16'hF1C0, 32'h0000_0000);
      rdchk(16'hF21C, 32'h0000_0000);
      check(spdif_tx_enable_o, 32'h0000_0000);
      $display("test reset values done");
      for (n = 0; n < 8; n++) acc(1'b1, 16'(16'hF200 + 4 * n), 16'(16'hA500 + n), d);
      acc(1'b1, 16'hF201, 16'hFFFF, d);
      rdchk(16'hF201, 32'h0000_0000);
      rdchk(16'hF198, 32'h0000_0000);
      for (n = 0; n < 8; n++) rdchk(16'(16'hF200 + 4 * n), 32'h0000_A500 + n);
      // Only the upper lane is enabled, so the low byte must survive
      be_sel = 4'h2;
      acc(1'b1, 16'hF204, 16'h5AFF, d);
      be_sel = 4'hF;
      rdchk(16'hF204, 32'h0000_5A01);
      $display("test port control map done");
      for (p = 0; p < 2; p++) begin
         exp_q.delete();
         sink_u.rx_q.delete();
         for (k = 0; k < 24; k++) begin
            code = p ? 3 : (k + 1) % 8;
            conv = k % 8;
            acc(1'b1, 16'(16'hF180 + k), {10'h000, conv[2:0], code[2:0]}, d);
            if (code >= 1 && code <= 5) exp_q.push_back({5'(k), src_pair(k, code, conv)});
         end
         hold_i <= (p == 0);
         @(posedge clk_i);
         frame_start_i <= 1'b1;
         @(posedge clk_i);
         frame_start_i <= 1'b0;
         if (p == 0) begin
            repeat (40) @(posedge clk_i);
            acc(1'b0, 16'hF1C4, 16'h0000, d);
            // Busy, refusing, holding a pair and stalled while the receiver waits
            check(d[3:0], 32'h0000_000F);
            hold_i <= 1'b0;
         end
         n = 0;
         do begin
            acc(1'b0, 16'hF1C4, 16'h0000, d);
            n++;
         end while (d[2:0] !== 3'h0 && n < 100);
         check(d[2:0], 32'h0000_0000);
         check(sink_u.rx_q.size(), exp_q.size());
         foreach (exp_q[i]) begin
            w = (i < sink_u.rx_q.size()) ? sink_u.rx_q[i] : '0;
            check(w[68:64], exp_q[i][68:64]);
            check(w[63:32], exp_q[i][63:32]);
            check(w[31:0], exp_q[i][31:0]);
         end
         $display("test routing pass %0d done", p);
      end
      rdchk(16'hF197, 32'h0000_003B);
      for (c = 0; c < 4; c++) begin
         // Receiver valid is raised for codes 2 and 3; code 3 must still stay quiet
         spdif_rx_valid_i <= c[1];
         acc(1'b1, 16'hF1C0, 16'(c), d);
         repeat (3) @(posedge clk_i);
         check(spdif_tx_enable_o, c == 1 || c == 2);
         check(spdif_tx_valid_o, c == 1 || c == 2);
         check(spdif_tx_left_o, c == 1 ? 32'hD000_0001 : c == 2 ? 32'hE000_0001 : 0);
         check(spdif_tx_right_o, c == 1 ? 32'hD000_0002 : c == 2 ? 32'hE000_0002 : 0);
      end
      rdchk(16'hF1C0, 32'h0000_0003);
      $display("test transmitter source done");
      tally_and_finish;
   end
endmodule
